//--- rtl/acs_coef_mem.v
// per-setup coefficient store with two registered read ports
`timescale 1ns/1ps
module acs_coef_mem #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter DW = 24
) (
  input wire clk, // system clock
  input wire we, // write strobe
  input wire [AW-1:0] waddr, // write setup index
  input wire [DW-1:0] wdata, // write data
  input wire [AW-1:0] raddr_a, // register read index
  output reg [DW-1:0] rdata_a, // register read data
  input wire [AW-1:0] raddr_b, // conversion read index
  output reg [DW-1:0] rdata_b // conversion read data
);
  reg [DW-1:0] mem_r [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_a <= mem_r[raddr_a];
    rdata_b <= mem_r[raddr_b];
  end
endmodule // acs_coef_mem

//--- rtl/acs_defs.vh
// register map, field positions and reset values of the setup sequencer
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_REG_CONV_MODE 8'h01
`define ACS_REG_PORT_MODE 8'h02
`define ACS_REG_CH_BASE 8'h10
`define ACS_REG_SETUP_BASE 8'h20
`define ACS_REG_FILT_BASE 8'h28
`define ACS_REG_OFS_BASE 8'h30
`define ACS_REG_GAIN_BASE 8'h38
`define ACS_CONV_MODE_RST 16'h8000
`define ACS_CONV_MODE_MASK 16'ha77c
`define ACS_PORT_MODE_RST 16'h0000
`define ACS_PORT_MODE_MASK 16'h1ded
`define ACS_CH0_RST 16'h8001
`define ACS_CHN_RST 16'h0001
`define ACS_CH_MASK 16'hf3ff
`define ACS_SETUP_RST 16'h1020
`define ACS_FILT_RST 16'h0000
`define ACS_OFS_RST 24'h800000
`define ACS_REF_EN_BIT 15
`define ACS_SINGLE_CYCLE_SETTLE_BIT 13
`define ACS_DELAY_HI 10
`define ACS_DELAY_LO 8
`define ACS_MODE_HI 6
`define ACS_MODE_LO 4
`define ACS_CLK_HI 3
`define ACS_CLK_LO 2
`define ACS_ALTERNATE_SYNC_FUNCTION_BIT 12
`define ACS_DRIVE_BIT 11
`define ACS_HIDE_DLY_BIT 10
`define ACS_OUT_RST_BIT 8
`define ACS_CONT_RD_BIT 7
`define ACS_STAT_APP_BIT 6
`define ACS_REG_CHK_BIT 5
`define ACS_CRC_HI 3
`define ACS_CRC_LO 2
`define ACS_SHORT_WORD_LENGTH_BIT 0
`define ACS_CH_EN_BIT 15
`define ACS_CH_SET_HI 14
`define ACS_CH_SET_LO 12
`define ACS_CH_POS_HI 9
`define ACS_CH_POS_LO 5
`define ACS_CH_NEG_HI 4
`define ACS_CH_NEG_LO 0
`define ACS_MODE_CONT 3'h0
`define ACS_MODE_SINGLE 3'h1
`define ACS_MODE_STANDBY 3'h2
`define ACS_MODE_PWRDN 3'h3
`define ACS_MODE_INT_ZS 3'h4
`define ACS_MODE_SYS_ZS 3'h6
`define ACS_MODE_SYS_FS 3'h7
`endif

//--- rtl/acs_sequencer.v
// configuration registers, coefficients and channel sequencer
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_sequencer #(
  parameter NCH = 4,
  parameter NSET = 4
) (
  input wire clk, // 125 MHz system clock
  input wire rst, // synchronous reset, active high
  input wire [47:0] trim_gain, // factory gain trims, 4 x 12 bits packed
  input wire reg_wr, // register write strobe from serial port
  input wire reg_rd, // register read strobe from serial port
  input wire [7:0] reg_addr, // register address
  input wire [23:0] reg_wdata, // register write data
  output reg [23:0] reg_rdata, // register read data
  output reg reg_rvalid, // read data valid pulse
  input wire conv_done, // filter finished one conversion
  input wire [23:0] cal_value, // calibration result
  output reg [2:0] mode, // converter operating mode field
  output reg [2:0] clk_src, // {pad,clock_source_choice}
  output reg ref_en, // internal reference enable
  output reg single_cycle_settle, // settle in one cycle
  output reg [2:0] settle_delay, // delay field
  output reg [15:0] port_mode, // serial_port_mode_control value
  output reg seq_active, // converting
  output reg [1:0] cur_ch, // channel being converted
  output reg [4:0] positive_input_choice, // mux positive pin
  output reg [4:0] negative_input_choice, // mux negative pin
  output reg [15:0] setup_configuration, // active setup config
  output reg [15:0] filter_configuration, // active filter config
  output reg [23:0] offset_coefficient, // active offset
  output reg [23:0] gain_coefficient // active gain
);
  ////////////////////////////////////////////////////////////////////////
  reg [15:0] conv_mode_r;
  reg [15:0] port_mode_r;
  reg [15:0] ch_r [0:NCH-1];
  reg [15:0] setup_r [0:NSET-1];
  reg [15:0] filt_r [0:NSET-1];
  reg [1:0] cur_r;
  reg [1:0] cur_nxt;
  reg trim_load_r;
  reg [1:0] trim_idx_r;
  wire [NCH-1:0] en_vec;
  reg rd_pend_r;
  reg [23:0] rd_hold_r;
  reg [1:0] rd_sel_r;
  wire [23:0] ofs_rd;
  wire [23:0] gain_rd;
  wire [23:0] ofs_cv;
  wire [23:0] gain_cv;
  wire [1:0] cur_setup;
  wire [2:0] mode_f;
  wire ofs_cal;
  wire gain_cal;
  wire ofs_hostwr;
  wire gain_hostwr;
  reg ofs_we;
  reg gain_we;
  reg [1:0] ofs_wa;
  reg [1:0] gain_wa;
  reg [23:0] ofs_wd;
  reg [23:0] gain_wd;
  integer i;
  integer j;
  genvar g;

  // true when the address falls inside a block of four registers
  function blk_hit;
    input [7:0] a;
    input [7:0] base;
    begin
      if (a >= base && a < base + 8'h04) begin
        blk_hit = 1'b1;
      end else begin
        blk_hit = 1'b0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // converter and serial port mode registers
  always @(posedge clk) begin
    if (rst) begin
      conv_mode_r <= `ACS_CONV_MODE_RST;
      port_mode_r <= `ACS_PORT_MODE_RST;
    end else if (reg_wr) begin
      if (reg_addr == `ACS_REG_CONV_MODE) begin
        conv_mode_r <= reg_wdata[15:0] & `ACS_CONV_MODE_MASK;
      end else if (reg_addr == `ACS_REG_PORT_MODE) begin
        port_mode_r <= reg_wdata[15:0] & `ACS_PORT_MODE_MASK;
      end
    end
  end

  assign mode_f = conv_mode_r[`ACS_MODE_HI:`ACS_MODE_LO];

  always @(posedge clk) begin
    if (rst) begin
      mode <= `ACS_MODE_CONT;
      clk_src <= 3'h0;
      ref_en <= 1'b1;
      single_cycle_settle <= 1'b0;
      settle_delay <= 3'h0;
      port_mode <= `ACS_PORT_MODE_RST;
    end else begin
      mode <= mode_f;
      clk_src <= {1'b0, conv_mode_r[`ACS_CLK_HI:`ACS_CLK_LO]};
      ref_en <= conv_mode_r[`ACS_REF_EN_BIT];
      single_cycle_settle <= conv_mode_r[`ACS_SINGLE_CYCLE_SETTLE_BIT];
      settle_delay <= conv_mode_r[`ACS_DELAY_HI:`ACS_DELAY_LO];
      port_mode <= port_mode_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel, setup and filter registers
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < NCH; i = i + 1) begin
        ch_r[i] <= (i == 0) ? `ACS_CH0_RST : `ACS_CHN_RST;
      end
      for (i = 0; i < NSET; i = i + 1) begin
        setup_r[i] <= `ACS_SETUP_RST;
        filt_r[i] <= `ACS_FILT_RST;
      end
    end else if (reg_wr) begin
      if (blk_hit(reg_addr, `ACS_REG_CH_BASE)) begin
        // positive/negative fields take any pin code
        ch_r[reg_addr[1:0]] <= reg_wdata[15:0] & `ACS_CH_MASK;
      end else if (blk_hit(reg_addr, `ACS_REG_SETUP_BASE)) begin
        setup_r[reg_addr[1:0]] <= reg_wdata[15:0];
      end else if (blk_hit(reg_addr, `ACS_REG_FILT_BASE)) begin
        filt_r[reg_addr[1:0]] <= reg_wdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // coefficient writes: host, calibration, power-on gain trim load
  assign ofs_hostwr = reg_wr && blk_hit(reg_addr, `ACS_REG_OFS_BASE);
  assign gain_hostwr = reg_wr && blk_hit(reg_addr, `ACS_REG_GAIN_BASE);
  assign ofs_cal = conv_done && (mode_f == `ACS_MODE_INT_ZS ||
                                 mode_f == `ACS_MODE_SYS_ZS);
  assign gain_cal = conv_done && (mode_f == `ACS_MODE_SYS_FS);
  assign cur_setup = ch_r[cur_r][13:12];

  // trim load walks all setups after reset; offsets reload mid-scale
  always @(posedge clk) begin
    if (rst) begin
      trim_load_r <= 1'b1;
      trim_idx_r <= 2'h0;
    end else if (trim_load_r) begin
      trim_idx_r <= trim_idx_r + 2'h1;
      if (trim_idx_r == NSET - 1) begin
        trim_load_r <= 1'b0;
      end
    end
  end

  always @* begin
    ofs_we = 1'b0;
    ofs_wa = 2'h0;
    ofs_wd = 24'h000000;
    gain_we = 1'b0;
    gain_wa = 2'h0;
    gain_wd = 24'h000000;
    if (trim_load_r) begin
      ofs_we = 1'b1;
      ofs_wa = trim_idx_r;
      ofs_wd = `ACS_OFS_RST;
      gain_we = 1'b1;
      gain_wa = trim_idx_r;
      // trim sits in the upper half, lower bits zero
      gain_wd = {trim_gain[trim_idx_r*12 +: 12], 12'h000};
    end else begin
      if (ofs_hostwr) begin
        ofs_we = 1'b1;
        ofs_wa = reg_addr[1:0];
        ofs_wd = reg_wdata;
      end else if (ofs_cal) begin
        ofs_we = 1'b1;
        ofs_wa = cur_setup;
        ofs_wd = cal_value;
      end
      if (gain_hostwr) begin
        gain_we = 1'b1;
        gain_wa = reg_addr[1:0];
        gain_wd = reg_wdata;
      end else if (gain_cal) begin
        gain_we = 1'b1;
        gain_wa = cur_setup;
        gain_wd = cal_value;
      end
    end
  end

  acs_coef_mem #(.DEPTH(NSET), .AW(2), .DW(24)) u_ofs (
    .clk(clk),
    .we(ofs_we),
    .waddr(ofs_wa),
    .wdata(ofs_wd),
    .raddr_a(reg_addr[1:0]),
    .rdata_a(ofs_rd),
    .raddr_b(cur_setup),
    .rdata_b(ofs_cv)
  );

  acs_coef_mem #(.DEPTH(NSET), .AW(2), .DW(24)) u_gain (
    .clk(clk),
    .we(gain_we),
    .waddr(gain_wa),
    .wdata(gain_wd),
    .raddr_a(reg_addr[1:0]),
    .rdata_a(gain_rd),
    .raddr_b(cur_setup),
    .rdata_b(gain_cv)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel sequencer
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_en
      assign en_vec[g] = ch_r[g][`ACS_CH_EN_BIT];
    end
  endgenerate

  // next enabled channel above current, else lowest enabled
  always @* begin
    cur_nxt = cur_r;
    for (j = NCH - 1; j >= 0; j = j - 1) begin
      if (en_vec[j]) begin
        cur_nxt = j[1:0];
      end
    end
    for (j = NCH - 1; j >= 0; j = j - 1) begin
      if (en_vec[j] && j > cur_r) begin
        cur_nxt = j[1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cur_r <= 2'h0;
    end else if (!en_vec[cur_r]) begin
      cur_r <= cur_nxt;
    end else if (conv_done && mode_f == `ACS_MODE_CONT) begin
      cur_r <= cur_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      seq_active <= 1'b0;
      cur_ch <= 2'h0;
      positive_input_choice <= 5'h00;
      negative_input_choice <= 5'h00;
      setup_configuration <= 16'h0000;
      filter_configuration <= 16'h0000;
      offset_coefficient <= 24'h000000;
      gain_coefficient <= 24'h000000;
    end else begin
      seq_active <= (|en_vec) && !trim_load_r &&
                    (mode_f == `ACS_MODE_CONT ||
                     mode_f == `ACS_MODE_SINGLE);
      cur_ch <= cur_r;
      positive_input_choice <= ch_r[cur_r][`ACS_CH_POS_HI:`ACS_CH_POS_LO];
      negative_input_choice <= ch_r[cur_r][`ACS_CH_NEG_HI:`ACS_CH_NEG_LO];
      setup_configuration <= setup_r[cur_setup];
      filter_configuration <= filt_r[cur_setup];
      offset_coefficient <= ofs_cv;
      gain_coefficient <= gain_cv;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: coefficient memory answers one cycle later
  always @(posedge clk) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_hold_r <= 24'h000000;
      rd_sel_r <= 2'h0;
    end else begin
      rd_pend_r <= reg_rd;
      rd_sel_r <= 2'h0;
      rd_hold_r <= 24'h000000;
      if (reg_addr == `ACS_REG_CONV_MODE) begin
        rd_hold_r <= {8'h00, conv_mode_r};
      end else if (reg_addr == `ACS_REG_PORT_MODE) begin
        rd_hold_r <= {8'h00, port_mode_r};
      end else if (blk_hit(reg_addr, `ACS_REG_CH_BASE)) begin
        rd_hold_r <= {8'h00, ch_r[reg_addr[1:0]]};
      end else if (blk_hit(reg_addr, `ACS_REG_SETUP_BASE)) begin
        rd_hold_r <= {8'h00, setup_r[reg_addr[1:0]]};
      end else if (blk_hit(reg_addr, `ACS_REG_FILT_BASE)) begin
        rd_hold_r <= {8'h00, filt_r[reg_addr[1:0]]};
      end else if (blk_hit(reg_addr, `ACS_REG_OFS_BASE)) begin
        rd_sel_r <= 2'h1;
      end else if (blk_hit(reg_addr, `ACS_REG_GAIN_BASE)) begin
        rd_sel_r <= 2'h2;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_r;
      if (rd_pend_r) begin
        if (rd_sel_r == 2'h1) begin
          reg_rdata <= ofs_rd;
        end else if (rd_sel_r == 2'h2) begin
          reg_rdata <= gain_rd;
        end else begin
          reg_rdata <= rd_hold_r;
        end
      end
    end
  end
endmodule // acs_sequencer

//--- test/acs_host_model.sv
// host controller model issuing register accesses
`timescale 1ns/1ps
module acs_host_model (
  input wire clk, // system clock
  output reg reg_wr, // write pulse
  output reg reg_rd, // read pulse
  output reg [7:0] reg_addr, // address
  output reg [23:0] reg_wdata // write data
);
  logic [23:0] exp_q[$];
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
  end
  // write data is inverted once released so stale values never look valid
  task wr(input [7:0] a, input [23:0] d);
    begin
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
    end
  endtask
  // address held two cycles past the pulse; the port uses it only in the pulse cycle
  task rd(input [7:0] a, input [23:0] e);
    begin
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      exp_q.push_back(e);
      @(negedge clk);
      reg_rd = 1'b0;
      repeat (2) @(negedge clk);
      reg_addr = ~a;
    end
  endtask
endmodule // acs_host_model

//--- test/acs_sequencer_sva.sv
// port-level checker for the configuration sequencer
`timescale 1ns/1ps
module acs_sva (
  input wire clk, // system clock
  input wire rst, // sync reset
  input wire reg_wr, // write pulse
  input wire reg_rd, // read pulse
  input wire [7:0] reg_addr, // address
  input wire [23:0] reg_wdata, // write data
  input wire [23:0] reg_rdata, // read data
  input wire reg_rvalid, // read valid
  input wire conv_done, // conversion done
  input wire [2:0] mode, // mode field
  input wire [2:0] clk_src, // clock source
  input wire ref_en, // reference enable
  input wire single_cycle_settle, // settle flag
  input wire [2:0] settle_delay, // delay field
  input wire [15:0] port_mode, // port mode copy
  input wire seq_active // converting
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  rd_latency_a: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer late");
  rv_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
    else $error("read answer without request");
  // rdata must stand while rvalid is low, except right after reset clears it
  rdata_hold_a: assert property (!reg_rvalid && !$past(rst) |->
    $stable(reg_rdata)) else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h3b
    |-> ##2 reg_rdata == 24'h000000) else $error("unmapped read not zero");
  op_mode_a: assert property (reg_wr && reg_addr == 8'h01
    |-> ##2 mode == $past(reg_wdata[6:4], 2)) else $error("mode field");
  clk_ref_a: assert property (reg_wr && reg_addr == 8'h01 |-> ##2
    ref_en == $past(reg_wdata[15], 2) &&
    clk_src == {1'b0, $past(reg_wdata[3:2], 2)})
    else $error("clock or reference field");
  delay_layout_a: assert property (reg_wr && reg_addr == 8'h01 |->
    ##2 settle_delay == $past(reg_wdata[10:8], 2) &&
    single_cycle_settle == $past(reg_wdata[13], 2))
    else $error("delay or settle field");
  port_layout_a: assert property (reg_wr && reg_addr == 8'h02 |->
    ##2 port_mode == ($past(reg_wdata[15:0], 2) & 16'h1ded))
    else $error("port mode layout");
  reset_copy_a: assert property ($fell(rst) |-> ref_en &&
    mode == 3'h0 && port_mode == 16'h0000) else $error("reset copies");
  trim_load_a: assert property ($fell(rst) |-> !seq_active [*3])
    else $error("sequencer ran during trim load");
  cover property (reg_rd ##2 reg_rvalid);
  cover property (conv_done && mode == 3'h0 && seq_active);
  cover property (conv_done && mode == 3'h7);
endmodule // acs_sva
bind acs_sequencer acs_sva i_sva (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
  .mode(mode), .clk_src(clk_src), .ref_en(ref_en),
  .single_cycle_settle(single_cycle_settle), .settle_delay(settle_delay),
  .port_mode(port_mode), .seq_active(seq_active));

//--- test/test_adc_setup_config_sequencer.sv
// self-checking bench for the configuration sequencer
`timescale 1ns/1ps
module test_adc_setup_config_sequencer;
  logic clk, rst, conv_done, reg_wr, reg_rd, reg_rvalid, seq_active;
  logic [47:0] trim_gain;
  logic [7:0] reg_addr, k;
  logic [23:0] reg_wdata, reg_rdata, cal_value, d, o0, o1, ofs;
  logic [1:0] cur_ch;
  logic [4:0] pos, neg;
  logic [15:0] scfg, fcfg;
  logic [23:0] gainc;
  logic [63:0] rv;
  integer seed, errors, check_count;
  logic [7:0] ta [0:5] = '{8'h01, 8'h02, 8'h30, 8'h31, 8'h38, 8'h7f};
  logic [23:0] tm [0:5] = '{24'h00a77c, 24'h001ded, 24'hffffff,
    24'hffffff, 24'hffffff, 24'h000000};
  logic [2:0] tcm [0:2] = '{3'h4, 3'h6, 3'h7};
  acs_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  acs_sequencer i_dut (.clk(clk), .rst(rst), .trim_gain(trim_gain),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_done(conv_done), .cal_value(cal_value), .mode(), .clk_src(),
    .ref_en(), .single_cycle_settle(), .settle_delay(), .port_mode(),
    .seq_active(seq_active), .cur_ch(cur_ch),
    .positive_input_choice(pos), .negative_input_choice(neg),
    .setup_configuration(scfg), .filter_configuration(fcfg),
    .offset_coefficient(ofs), .gain_coefficient(gainc));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task check(input string nm, input [23:0] ex, input [23:0] got);
    begin
      check_count = check_count + 1;
      if (got !== ex) begin
        errors = errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && check_count > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  task pulse(input [23:0] cv);
    begin
      @(negedge clk);
      conv_done = 1'b1;
      cal_value = cv;
      @(negedge clk);
      conv_done = 1'b0;
      cal_value = ~cv;
      repeat (4) @(negedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      check("reg_rdata", i_host.exp_q.pop_front(), reg_rdata);
    end
  end
  initial begin
    #100000;
    errors = errors + 1;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'haf1789f1;
    errors = 0;
    check_count = 0;
    clk = 1'b0;
    rst = 1'b1;
    conv_done = 1'b0;
    cal_value = 24'h000000;
    rv = {$random(seed), $random(seed)};
    trim_gain = rv[47:0];
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    i_host.rd(8'h01, 24'h008000);
    i_host.rd(8'h02, 24'h000000);
    for (k = 0; k < 4; k = k + 1) begin
      i_host.rd(8'h10 + k, k == 0 ? 24'h008001 : 24'h000001);
      i_host.rd(8'h20 + k, 24'h001020);
      i_host.rd(8'h30 + k, 24'h800000);
      i_host.rd(8'h38 + k, {trim_gain[12*k +: 12], 12'h000});
    end
    for (k = 0; k < 6; k = k + 1) begin
      d = 24'($random(seed));
      i_host.wr(ta[k], d);
      i_host.rd(ta[k], d & tm[k]);
    end
    o0 = 24'($random(seed));
    o1 = 24'($random(seed));
    i_host.wr(8'h01, 24'h008000);
    i_host.wr(8'h30, o0);
    i_host.wr(8'h31, o1);
    // channel 2 on setup 1, pins 2 and 4; the host sets the msb
    i_host.wr(8'h12, 24'h009044);
    for (k = 0; k < 3; k = k + 1) begin
      pulse(24'h000000);
      check("cur_ch", k[0] ? 24'h0 : 24'h2, {22'h0, cur_ch});
      check("offset", k[0] ? o0 : o1, ofs);
      check("pins", k[0] ? 24'h001 : 24'h044, {14'h0, pos, neg});
    end
    i_host.wr(8'h11, 24'h009001);
    i_host.wr(8'h21, 24'h001010);
    i_host.wr(8'h29, 24'h00000a);
    pulse(24'h000000);
    pulse(24'h000000);
    check("cur_ch", 24'h1, {22'h0, cur_ch});
    check("shared", o1, ofs);
    check("active", 24'h1, {23'h0, seq_active});
    check("setup", 24'h001010, {8'h0, scfg});
    check("filter", 24'h00000a, {8'h0, fcfg});
    for (k = 0; k < 3; k = k + 1) begin
      d = 24'($random(seed));
      i_host.wr(8'h01, {16'h0080, 1'b0, tcm[k], 4'h0});
      pulse(d);
      i_host.rd(tcm[k] == 3'h7 ? 8'h39 : 8'h31, d);
    end
    check("gain", d, gainc);
    repeat (4) @(negedge clk);
    tally_and_finish;
  end
endmodule // test_adc_setup_config_sequencer
